// >>> fpo_defs.vh
/*
 * Register offsets, field positions, reset values and source counts for the
 * fan duty override and readback block.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef FPO_DEFS_VH
`define FPO_DEFS_VH

// Register offsets on the 8-bit command space.
`define FPO_ZONE1B_FILT_OFS 8'h08
`define FPO_ZONE2B_FILT_OFS 8'h09
`define FPO_FAN_A_READBACK_OFS 8'h0a
`define FPO_FAN_B_READBACK_OFS 8'h0b
`define FPO_FAN_A_OVR_LOW_OFS 8'h0c
`define FPO_FAN_A_OVR_HIGH_OFS 8'h0d
`define FPO_FAN_B_OVR_LOW_OFS 8'h0e
`define FPO_FAN_B_OVR_HIGH_OFS 8'h0f
`define FPO_ZONE1A_FILT_OFS 8'h54
`define FPO_ZONE2A_FILT_OFS 8'h55

// Reset values.
`define FPO_TEMP_RST 8'h00
`define FPO_READBACK_RST 8'h00
`define FPO_OVR_LOW_RST 8'h00
`define FPO_OVR_HIGH_RST 8'h00
`define FPO_DUTY_RST 9'h000
`define FPO_SMOOTH_RST 8'h00
`define FPO_UNMAPPED_DATA 8'h00
`define FPO_OVR_EN_RST 1'b0
`define FPO_FLAG_RST 1'b0
`define FPO_RD_DATA_RST 8'h00

// Field positions in an override low-byte register.
`define FPO_OVR_LSB_BIT 7
`define FPO_OVR_EN_BIT 6
`define FPO_OVR_RES_MASK 8'h3f

// Nine-bit duty scale: 100h is full duty.
`define FPO_DUTY_FULL 9'h100

// Automatic sources per output.
`define FPO_NUM_LOW 4
`define FPO_NUM_HIGH 2

`endif

// >>> fpo_duty_select.v
/*
 * Duty selection for one fan output: the largest duty among its bound
 * automatic sources, replaced by the manual override when that is enabled,
 * and forced to full duty by the status control force.
 * Assumes all inputs come from logic on the same clock; purely combinational.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fpo_defs.vh"

module fpo_duty_select (
    // Automatic sources.
    input wire [`FPO_NUM_LOW*8-1:0] low_req,
    input wire [`FPO_NUM_LOW-1:0] low_bind,
    input wire [`FPO_NUM_HIGH*9-1:0] high_req,
    input wire [`FPO_NUM_HIGH-1:0] high_bind,
    // Manual override and force.
    input wire ovr_en,
    input wire [8:0] ovr_duty,
    input wire force_full,
    // Result.
    output reg [8:0] duty
);

    integer i;
    reg [8:0] auto_max;
    reg [8:0] cand;

    always @* begin
        auto_max = 9'h000;
        cand = 9'h000;
        // Low-resolution requests sit in the upper eight bits of the nine-bit scale.
        for (i = 0; i < `FPO_NUM_LOW; i = i + 1) begin
            cand = {low_req[i*8 +: 8], 1'b0};
            if (low_bind[i] && cand > auto_max) begin
                auto_max = cand;
            end
        end
        for (i = 0; i < `FPO_NUM_HIGH; i = i + 1) begin
            cand = high_req[i*9 +: 9];
            if (high_bind[i] && cand > auto_max) begin
                auto_max = cand;
            end
        end
        if (force_full) begin
            duty = `FPO_DUTY_FULL;
        end else if (ovr_en) begin
            duty = ovr_duty;
        end else begin
            duty = auto_max;
        end
    end

endmodule // fpo_duty_select

`default_nettype wire

// >>> fpo_fan_override.v
/*
 * Fan duty override and readback block: filtered zone temperature registers,
 * duty readback registers and the nine-bit manual override registers of the
 * two fan outputs, with the duty chosen for each output.
 * Assumes a register access port driven by the serial interface engine on
 * sys_clk, automatic duty sources and filter results on the same clock, and a
 * force-full level from the status control register held elsewhere.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fpo_defs.vh"

// Operation
// - Four read-only registers hold the smoothed zone 1 and zone 2 temperatures and reset to zero.
// - The smoothing filter is tuned through a separate smoothing control value, not fixed here.
// - Each fan output has a read-only register showing the duty it is currently driven at.
// - A readback register holds only the upper eight bits of its output's nine-bit duty.
// - The automatic duty is the largest request of any low- or high-resolution source bound to the output.
// - With bit 6 of output A's low override byte set, output A runs at the nine-bit override over 256.
// - Bit 7 of each low override byte is the duty's least bit, and bits 5 to 0 read as zero.
// - Each high override byte holds bits 8 to 1 of that output's nine-bit override duty.
// - While output A's override is on, all other sources are ignored except the forced full duty.
// - With bit 6 of output B's low override byte set, output B runs at its nine-bit override over 256.
// - While output B's override is on, all other sources are ignored except the forced full duty.
module fpo_fan_override (
    // Clock and reset.
    input wire sys_clk,
    input wire reset_n,
    // Register access from the serial interface engine.
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    output reg [7:0] reg_rd_data_q,
    output reg reg_rd_valid_q,
    // Filtered temperatures from the smoothing filter.
    input wire filt_update,
    input wire [7:0] zone1a_filt,
    input wire [7:0] zone1b_filt,
    input wire [7:0] zone2a_filt,
    input wire [7:0] zone2b_filt,
    // Smoothing control value and its copy towards the filter.
    input wire [7:0] smooth_ctrl,
    output reg [7:0] smooth_tune_q,
    // Forced full duty from the status control register.
    input wire fan_a_force_full,
    input wire fan_b_force_full,
    // Low-resolution automatic requests for output A.
    input wire [7:0] fan_a_low_req0,
    input wire [7:0] fan_a_low_req1,
    input wire [7:0] fan_a_low_req2,
    input wire [7:0] fan_a_low_req3,
    input wire [3:0] fan_a_low_bind,
    // High-resolution automatic requests for output A.
    input wire [8:0] fan_a_high_req0,
    input wire [8:0] fan_a_high_req1,
    input wire [1:0] fan_a_high_bind,
    // Low-resolution automatic requests for output B.
    input wire [7:0] fan_b_low_req0,
    input wire [7:0] fan_b_low_req1,
    input wire [7:0] fan_b_low_req2,
    input wire [7:0] fan_b_low_req3,
    input wire [3:0] fan_b_low_bind,
    // High-resolution automatic requests for output B.
    input wire [8:0] fan_b_high_req0,
    input wire [8:0] fan_b_high_req1,
    input wire [1:0] fan_b_high_bind,
    // Duty driven on each output, towards the waveform generator.
    output reg [8:0] fan_output_a_duty_q,
    output reg [8:0] fan_output_b_duty_q,
    // Override state, for the binding logic that reports it.
    output reg fan_a_override_active_q,
    output reg fan_b_override_active_q
);

    // Stored registers.
    reg [7:0] zone1a_filt_q;
    reg [7:0] zone1b_filt_q;
    reg [7:0] zone2a_filt_q;
    reg [7:0] zone2b_filt_q;
    reg fan_a_fine_override_enable_q;
    reg fan_b_fine_override_enable_q;
    reg [8:0] fan_a_override_duty_q;
    reg [8:0] fan_b_override_duty_q;
    reg [7:0] fan_a_readback_q;
    reg [7:0] fan_b_readback_q;

    // Decoded strobes.
    reg wr_a_low;
    reg wr_a_high;
    reg wr_b_low;
    reg wr_b_high;

    // Selected duties and read path.
    wire [8:0] fan_a_duty_d;
    wire [8:0] fan_b_duty_d;
    reg [7:0] rd_data_d;
    reg [7:0] ovr_a_low_view;
    reg [7:0] ovr_b_low_view;

    // Write decode. Writes to read-only or foreign offsets match no strobe and
    // are dropped here without any error indication.
    always @* begin
        wr_a_low = 1'b0;
        wr_a_high = 1'b0;
        wr_b_low = 1'b0;
        wr_b_high = 1'b0;
        if (reg_wr_en) begin
            case (reg_addr)
                `FPO_FAN_A_OVR_LOW_OFS: begin
                    wr_a_low = 1'b1;
                end
                `FPO_FAN_A_OVR_HIGH_OFS: begin
                    wr_a_high = 1'b1;
                end
                `FPO_FAN_B_OVR_LOW_OFS: begin
                    wr_b_low = 1'b1;
                end
                `FPO_FAN_B_OVR_HIGH_OFS: begin
                    wr_b_high = 1'b1;
                end
                default: begin
                    wr_a_low = 1'b0;
                end
            endcase
        end
    end

    // Filtered temperatures are captured only on the filter's update strobe, so
    // a read between updates sees a stable value rather than a moving one. All
    // four share the strobe, so reads between two updates agree with each other.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zone1a_filt_q <= `FPO_TEMP_RST;
        end else if (filt_update) begin
            zone1a_filt_q <= zone1a_filt;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zone1b_filt_q <= `FPO_TEMP_RST;
        end else if (filt_update) begin
            zone1b_filt_q <= zone1b_filt;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zone2a_filt_q <= `FPO_TEMP_RST;
        end else if (filt_update) begin
            zone2a_filt_q <= zone2a_filt;
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            zone2b_filt_q <= `FPO_TEMP_RST;
        end else if (filt_update) begin
            zone2b_filt_q <= zone2b_filt;
        end
    end

    // The filter takes its tuning from here; its characteristics are not fixed
    // inside this block.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            smooth_tune_q <= `FPO_SMOOTH_RST;
        end else begin
            smooth_tune_q <= smooth_ctrl;
        end
    end

    // Override registers for output A. The two bytes are not shadowed: each
    // byte takes effect on its own write, so software that changes the duty
    // while the override is on should write the high byte last or accept one
    // intermediate value.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_a_fine_override_enable_q <= `FPO_OVR_EN_RST;
        end else if (wr_a_low) begin
            fan_a_fine_override_enable_q <= reg_wr_data[`FPO_OVR_EN_BIT];
        end
    end

    // Override duty for output A, taken a byte at a time.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_a_override_duty_q <= `FPO_DUTY_RST;
        end else begin
            if (wr_a_low) begin
                fan_a_override_duty_q[0] <= reg_wr_data[`FPO_OVR_LSB_BIT];
            end
            if (wr_a_high) begin
                fan_a_override_duty_q[8:1] <= reg_wr_data;
            end
        end
    end

    // Override enable for output B.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_b_fine_override_enable_q <= `FPO_OVR_EN_RST;
        end else if (wr_b_low) begin
            fan_b_fine_override_enable_q <= reg_wr_data[`FPO_OVR_EN_BIT];
        end
    end

    // Override duty for output B, taken a byte at a time.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_b_override_duty_q <= `FPO_DUTY_RST;
        end else begin
            if (wr_b_low) begin
                fan_b_override_duty_q[0] <= reg_wr_data[`FPO_OVR_LSB_BIT];
            end
            if (wr_b_high) begin
                fan_b_override_duty_q[8:1] <= reg_wr_data;
            end
        end
    end

    // Values above full duty are passed through unchanged; the waveform
    // generator treats anything at or above 100h as always on.
    fpo_duty_select u_sel_a (
        .low_req({fan_a_low_req3, fan_a_low_req2, fan_a_low_req1, fan_a_low_req0}),
        .low_bind(fan_a_low_bind),
        .high_req({fan_a_high_req1, fan_a_high_req0}),
        .high_bind(fan_a_high_bind),
        .ovr_en(fan_a_fine_override_enable_q),
        .ovr_duty(fan_a_override_duty_q),
        .force_full(fan_a_force_full),
        .duty(fan_a_duty_d)
    );

    fpo_duty_select u_sel_b (
        .low_req({fan_b_low_req3, fan_b_low_req2, fan_b_low_req1, fan_b_low_req0}),
        .low_bind(fan_b_low_bind),
        .high_req({fan_b_high_req1, fan_b_high_req0}),
        .high_bind(fan_b_high_bind),
        .ovr_en(fan_b_fine_override_enable_q),
        .ovr_duty(fan_b_override_duty_q),
        .force_full(fan_b_force_full),
        .duty(fan_b_duty_d)
    );

    // The driven duty and its readback are taken from the same edge, so the
    // readback always matches what the output is running at.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_output_a_duty_q <= `FPO_DUTY_RST;
            fan_a_readback_q <= `FPO_READBACK_RST;
            fan_a_override_active_q <= `FPO_FLAG_RST;
        end else begin
            fan_output_a_duty_q <= fan_a_duty_d;
            fan_a_readback_q <= fan_a_duty_d[8:1];
            fan_a_override_active_q <= fan_a_fine_override_enable_q;
        end
    end

    // Output B, on the same edge as output A.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fan_output_b_duty_q <= `FPO_DUTY_RST;
            fan_b_readback_q <= `FPO_READBACK_RST;
            fan_b_override_active_q <= `FPO_FLAG_RST;
        end else begin
            fan_output_b_duty_q <= fan_b_duty_d;
            fan_b_readback_q <= fan_b_duty_d[8:1];
            fan_b_override_active_q <= fan_b_fine_override_enable_q;
        end
    end

    // Low override bytes as read back: reserved bits read as zero.
    always @* begin
        ovr_a_low_view = 8'h00;
        ovr_a_low_view[`FPO_OVR_LSB_BIT] = fan_a_override_duty_q[0];
        ovr_a_low_view[`FPO_OVR_EN_BIT] = fan_a_fine_override_enable_q;
    end

    always @* begin
        ovr_b_low_view = 8'h00;
        ovr_b_low_view[`FPO_OVR_LSB_BIT] = fan_b_override_duty_q[0];
        ovr_b_low_view[`FPO_OVR_EN_BIT] = fan_b_fine_override_enable_q;
    end

    // Read multiplexer. Offsets that this block does not own read as zero so
    // that a shared read bus can OR the answers of several blocks together.
    always @* begin
        case (reg_addr)
            `FPO_ZONE1B_FILT_OFS: begin
                rd_data_d = zone1b_filt_q;
            end
            `FPO_ZONE2B_FILT_OFS: begin
                rd_data_d = zone2b_filt_q;
            end
            `FPO_ZONE1A_FILT_OFS: begin
                rd_data_d = zone1a_filt_q;
            end
            `FPO_ZONE2A_FILT_OFS: begin
                rd_data_d = zone2a_filt_q;
            end
            `FPO_FAN_A_READBACK_OFS: begin
                rd_data_d = fan_a_readback_q;
            end
            `FPO_FAN_B_READBACK_OFS: begin
                rd_data_d = fan_b_readback_q;
            end
            `FPO_FAN_A_OVR_LOW_OFS: begin
                rd_data_d = ovr_a_low_view & ~`FPO_OVR_RES_MASK;
            end
            `FPO_FAN_A_OVR_HIGH_OFS: begin
                rd_data_d = fan_a_override_duty_q[8:1];
            end
            `FPO_FAN_B_OVR_LOW_OFS: begin
                rd_data_d = ovr_b_low_view & ~`FPO_OVR_RES_MASK;
            end
            `FPO_FAN_B_OVR_HIGH_OFS: begin
                rd_data_d = fan_b_override_duty_q[8:1];
            end
            default: begin
                rd_data_d = `FPO_UNMAPPED_DATA;
            end
        endcase
    end

    // Read answer one cycle after the request; data holds until the next read.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_valid_q <= `FPO_FLAG_RST;
        end else begin
            reg_rd_valid_q <= reg_rd_en;
        end
    end

    // A read of an unmapped offset still answers, with zero data, so the
    // serial engine never waits on this block.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data_q <= `FPO_RD_DATA_RST;
        end else if (reg_rd_en) begin
            reg_rd_data_q <= rd_data_d;
        end
    end

endmodule // fpo_fan_override

`default_nettype wire

// >>> fpo_checker_properties.sv
/*
 * Concurrent checks on the ports of the fan duty override block.
 * Assumes one clock domain, sys_clk, with reset_n as its asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module fpo_checker (
    // Clock, reset and register port.
    input wire sys_clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_rd_data_q,
    input wire reg_rd_valid_q,
    // Controls and results.
    input wire [7:0] smooth_ctrl,
    input wire [7:0] smooth_tune_q,
    input wire fan_a_force_full,
    input wire fan_b_force_full,
    input wire [8:0] fan_output_a_duty_q,
    input wire [8:0] fan_output_b_duty_q,
    input wire fan_a_override_active_q,
    input wire fan_b_override_active_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire [7:0] hi_a;
    wire [7:0] hi_b;
    assign hi_a = fan_output_a_duty_q[8:1];
    assign hi_b = fan_output_b_duty_q[8:1];
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid_q)
        else $error("read without answer");
    a_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid_q)
        else $error("read answer without request");
    a_readback_a_upper: assert property ((reg_rd_en && reg_addr == 8'h0a) |=> reg_rd_data_q == $past(hi_a))
        else $error("output a readback differs from driven duty");
    a_readback_b_upper: assert property ((reg_rd_en && reg_addr == 8'h0b) |=> reg_rd_data_q == $past(hi_b))
        else $error("output b readback differs from driven duty");
    a_low_res_zero: assert property ((reg_rd_en && (reg_addr == 8'h0c || reg_addr == 8'h0e))
        |=> reg_rd_data_q[5:0] == 6'h00)
        else $error("reserved override bits read nonzero");
    a_force_a_full: assert property (fan_a_force_full |=> fan_output_a_duty_q == 9'h100)
        else $error("output a not at full duty under force");
    a_force_b_full: assert property (fan_b_force_full |=> fan_output_b_duty_q == 9'h100)
        else $error("output b not at full duty under force");
    // Writes are excluded because a new override byte legitimately moves the duty.
    a_ovr_a_hold: assert property ((fan_a_override_active_q && !fan_a_force_full && !$past(fan_a_force_full)
        && !reg_wr_en && !$past(reg_wr_en)) |=> (!fan_a_override_active_q || $stable(fan_output_a_duty_q)))
        else $error("output a moved while override held");
    a_ovr_b_hold: assert property ((fan_b_override_active_q && !fan_b_force_full && !$past(fan_b_force_full)
        && !reg_wr_en && !$past(reg_wr_en)) |=> (!fan_b_override_active_q || $stable(fan_output_b_duty_q)))
        else $error("output b moved while override held");
    a_smooth_copy: assert property ($past(reset_n) |-> smooth_tune_q == $past(smooth_ctrl))
        else $error("smoothing control not passed on");
endmodule // fpo_checker
bind fpo_fan_override fpo_checker i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q), .reg_rd_valid_q(reg_rd_valid_q),
    .smooth_ctrl(smooth_ctrl), .smooth_tune_q(smooth_tune_q), .fan_a_force_full(fan_a_force_full),
    .fan_b_force_full(fan_b_force_full), .fan_output_a_duty_q(fan_output_a_duty_q),
    .fan_output_b_duty_q(fan_output_b_duty_q), .fan_a_override_active_q(fan_a_override_active_q),
    .fan_b_override_active_q(fan_b_override_active_q));
`default_nettype wire

// >>> fpo_host_model.sv
/*
 * Host model for the register access port of the fan duty override block.
 * Assumes the shared sys_clk; requests change at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module fpo_host_model (
    // Clock.
    input wire sys_clk,
    // Register access port.
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire [7:0] reg_rd_data_q,
    input wire reg_rd_valid_q
);
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // Idle address and data show the inverse of their last value, so a stale bus cannot pass for a request.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        ok = reg_rd_valid_q;
        d = reg_rd_data_q;
    endtask
endmodule // fpo_host_model
`default_nettype wire

// >>> test_fpo_fan_override.sv
/*
 * Self-checking testbench for the fan duty override block.
 * Assumes the host model and checker files are compiled before it.
 */
`timescale 1ns/1ns
`default_nettype none
module test_fpo_fan_override;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    wire [7:0] reg_addr, reg_wr_data, reg_rd_data_q, smooth_tune_q;
    wire reg_wr_en, reg_rd_en, reg_rd_valid_q, ov_a, ov_b;
    wire [8:0] duty_a, duty_b;
    logic filt_update, force_a, force_b;
    logic [7:0] smooth_ctrl, rdat;
    logic rok;
    logic [7:0] zt [4];
    logic [7:0] lo_a [4];
    logic [7:0] lo_b [4];
    logic [8:0] hr_a [2];
    logic [8:0] hr_b [2];
    logic [3:0] bl_a, bl_b;
    logic [1:0] bh_a, bh_b;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] addrs [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h54, 8'h55, 8'h10};

    fpo_fan_override i_fpo_fan_override (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q),
        .reg_rd_valid_q(reg_rd_valid_q), .filt_update(filt_update), .zone1a_filt(zt[0]), .zone1b_filt(zt[1]),
        .zone2a_filt(zt[2]), .zone2b_filt(zt[3]), .smooth_ctrl(smooth_ctrl), .smooth_tune_q(smooth_tune_q),
        .fan_a_force_full(force_a), .fan_b_force_full(force_b), .fan_a_low_req0(lo_a[0]), .fan_a_low_req1(lo_a[1]),
        .fan_a_low_req2(lo_a[2]), .fan_a_low_req3(lo_a[3]), .fan_a_low_bind(bl_a), .fan_a_high_req0(hr_a[0]),
        .fan_a_high_req1(hr_a[1]), .fan_a_high_bind(bh_a), .fan_b_low_req0(lo_b[0]), .fan_b_low_req1(lo_b[1]),
        .fan_b_low_req2(lo_b[2]), .fan_b_low_req3(lo_b[3]), .fan_b_low_bind(bl_b), .fan_b_high_req0(hr_b[0]),
        .fan_b_high_req1(hr_b[1]), .fan_b_high_bind(bh_b), .fan_output_a_duty_q(duty_a),
        .fan_output_b_duty_q(duty_b), .fan_a_override_active_q(ov_a), .fan_b_override_active_q(ov_b));
    fpo_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q), .reg_rd_valid_q(reg_rd_valid_q));

    always #4 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // The run needs well under a thousand cycles; a hang is cut at three thousand.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rdat, rok);
        chk({8'h00, rok}, 9'h001);
        chk({1'b0, rdat}, {1'b0, exp});
    endtask
    task automatic settle;
        repeat (3) @(negedge sys_clk);
    endtask

    initial begin
        filt_update = 1'b0;
        force_a = 1'b0;
        force_b = 1'b0;
        smooth_ctrl = 8'h00;
        zt = '{8'h11, 8'h22, 8'h33, 8'h44};
        lo_a = '{8'h10, 8'h20, 8'h30, 8'h40};
        lo_b = '{8'h01, 8'h02, 8'h03, 8'h44};
        hr_a = '{9'h05f, 9'h0ff};
        hr_b = '{9'h0aa, 9'h0bb};
        bl_a = 4'h0;
        bl_b = 4'h0;
        bh_a = 2'h0;
        bh_b = 2'h0;
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
        filt_update = 1'b1;
        @(negedge sys_clk);
        filt_update = 1'b0;
        host.wr(8'h08, 8'hff);
        rd_chk(8'h54, 8'h11);
        rd_chk(8'h08, 8'h22);
        rd_chk(8'h55, 8'h33);
        rd_chk(8'h09, 8'h44);
        smooth_ctrl = 8'h5a;
        settle;
        chk({1'b0, smooth_tune_q}, 9'h05a);
        bl_a = 4'b0111;
        bh_a = 2'b01;
        bl_b = 4'b1000;
        settle;
        chk(duty_a, 9'h060);
        chk(duty_b, 9'h088);
        rd_chk(8'h0a, 8'h30);
        rd_chk(8'h0b, 8'h44);
        bh_a = 2'b11;
        bh_b = 2'b10;
        settle;
        chk(duty_a, 9'h0ff);
        chk(duty_b, 9'h0bb);
        rd_chk(8'h0b, 8'h5d);
        host.wr(8'h0a, 8'h00);
        rd_chk(8'h0a, 8'h7f);
        host.wr(8'h0d, 8'h12);
        settle;
        chk(duty_a, 9'h0ff);
        host.wr(8'h0c, 8'hff);
        settle;
        chk(duty_a, 9'h025);
        chk({8'h00, ov_a}, 9'h001);
        rd_chk(8'h0c, 8'hc0);
        rd_chk(8'h0d, 8'h12);
        rd_chk(8'h0a, 8'h12);
        bl_a = 4'hf;
        settle;
        chk(duty_a, 9'h025);
        force_a = 1'b1;
        settle;
        chk(duty_a, 9'h100);
        force_a = 1'b0;
        // Full duty is the largest legal override value.
        host.wr(8'h0f, 8'h80);
        host.wr(8'h0e, 8'h40);
        settle;
        chk(duty_b, 9'h100);
        chk({8'h00, ov_b}, 9'h001);
        rd_chk(8'h0b, 8'h80);
        rd_chk(8'h0e, 8'h40);
        rd_chk(8'h0f, 8'h80);
        host.wr(8'h0f, 8'h00);
        settle;
        chk(duty_b, 9'h000);
        force_b = 1'b1;
        settle;
        chk(duty_b, 9'h100);
        force_b = 1'b0;
        host.wr(8'h0c, 8'h80);
        settle;
        chk(duty_a, 9'h0ff);
        chk({8'h00, ov_a}, 9'h000);
        host.wr(8'h10, 8'h77);
        rd_chk(8'h10, 8'h00);
        wrap_up;
    end
endmodule // test_fpo_fan_override
`default_nettype wire
